// [hdl/nmisl_pkg.sv]
package nmisl_pkg;

    // i/o port addresses
    localparam logic [15:0] NMISL_PORT_MAIN   = 16'h0061;
    localparam logic [15:0] NMISL_PORT_MASK   = 16'h0070;
    localparam logic [15:0] NMISL_PORT_EXT    = 16'h0461;
    localparam logic [15:0] NMISL_PORT_SWTRIG = 16'h0462;

    // main port fields
    localparam int NMISL_MAIN_PAR_STAT  = 7;
    localparam int NMISL_MAIN_CHK_STAT  = 6;
    localparam int NMISL_MAIN_CHK_DIS   = 3;
    localparam int NMISL_MAIN_PAR_DIS   = 2;

    // extended port fields
    localparam int NMISL_EXT_FST_STAT   = 7;
    localparam int NMISL_EXT_BTO_STAT   = 6;
    localparam int NMISL_EXT_SW_STAT    = 5;
    localparam int NMISL_EXT_BTO_DIS    = 3;
    localparam int NMISL_EXT_FST_DIS    = 2;
    localparam int NMISL_EXT_SW_DIS     = 1;
    localparam int NMISL_EXT_BUS_RST    = 0;

    // mask port field
    localparam int NMISL_MASK_ALL       = 7;

    // reset values
    localparam logic [3:0] NMISL_MAIN_CTL_RST = 4'h0;
    localparam logic [3:0] NMISL_EXT_CTL_RST  = 4'h0;
    localparam logic [7:0] NMISL_MASK_RST     = 8'h00;
    localparam logic       NMISL_STAT_RST     = 1'h0;
    localparam logic [7:0] NMISL_RDATA_RST    = 8'h00;

    // timing
    localparam int NMISL_CLK_MHZ        = 50;
    localparam int NMISL_MASTER_TO_US   = 8;
    localparam int NMISL_CMD_TO_US      = 32;
    localparam int NMISL_MASTER_TO_CYC  = NMISL_MASTER_TO_US * NMISL_CLK_MHZ;
    localparam int NMISL_CMD_TO_CYC     = NMISL_CMD_TO_US * NMISL_CLK_MHZ;
    localparam int NMISL_CNT_W          = 11;
    localparam logic [NMISL_CNT_W-1:0] NMISL_CNT_RST = 11'h000;

endpackage : nmisl_pkg

// [hdl/nmisl_top.sv]
// Operation
// - parity input latches main status bit 7
// - low channel check latches main status bit 6
// - fail-safe timeout rising edge latches extended bit7
// - master holding 8us without ack: nmi and reset
// - no master timeout while cpu owns bus
// - command active over 32us: nmi and reset
// - timeout reset held until extended bit3 cleared
// - write to trigger port raises software nmi
// - four byte ports, status reads show sources
// - writing disable bit high clears status
// - mask bit 7 gates all nmi sources
// - nmi is level while any source pends
// - extended bit 0 drives bus reset directly
`timescale 1ns/1ps

module nmisl_top
    import nmisl_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic [15:0] io_addr,
    input  wire logic        io_wr,
    input  wire logic        io_rd,
    input  wire logic [7:0]  io_wdata,
    output logic      [7:0]  io_rdata,
    input  wire logic        parity_err_n,
    input  wire logic        chan_check_n,
    input  wire logic        fail_safe_out,
    input  wire logic        master_owns_bus,
    input  wire logic        master_ack,
    input  wire logic        cpu_owns_bus,
    input  wire logic        cmd_active_n,
    output logic             nmi,
    output logic             bus_reset
);

    logic [3:0]             main_ctl_ff;
    logic [3:0]             ext_ctl_ff;
    logic [7:0]             mask_ff;
    logic                   par_stat_ff;
    logic                   chk_stat_ff;
    logic                   fst_stat_ff;
    logic                   bto_stat_ff;
    logic                   sw_stat_ff;
    logic                   fst_prev_ff;
    logic                   to_rst_ff;
    logic [NMISL_CNT_W-1:0] mst_cnt_ff;
    logic [NMISL_CNT_W-1:0] cmd_cnt_ff;
    logic [7:0]             rdata_ff;

    wire sel_main = (io_addr == NMISL_PORT_MAIN);
    wire sel_mask = (io_addr == NMISL_PORT_MASK);
    wire sel_ext  = (io_addr == NMISL_PORT_EXT);
    wire sel_sw   = (io_addr == NMISL_PORT_SWTRIG);
    wire wr_main  = io_wr && sel_main;
    wire wr_mask  = io_wr && sel_mask;
    wire wr_ext   = io_wr && sel_ext;
    wire wr_sw    = io_wr && sel_sw;

    // a disable bit held high blocks new events; the write that sets it clears its status
    wire par_dis = main_ctl_ff[NMISL_MAIN_PAR_DIS];
    wire chk_dis = main_ctl_ff[NMISL_MAIN_CHK_DIS];
    wire fst_dis = ext_ctl_ff[NMISL_EXT_FST_DIS];
    wire bto_dis = ext_ctl_ff[NMISL_EXT_BTO_DIS];
    wire sw_dis  = ext_ctl_ff[NMISL_EXT_SW_DIS];

    wire par_clr = wr_main && io_wdata[NMISL_MAIN_PAR_DIS];
    wire chk_clr = wr_main && io_wdata[NMISL_MAIN_CHK_DIS];
    wire fst_clr = wr_ext && io_wdata[NMISL_EXT_FST_DIS];
    wire bto_clr = wr_ext && io_wdata[NMISL_EXT_BTO_DIS];
    wire sw_clr  = wr_ext && io_wdata[NMISL_EXT_SW_DIS];

    // events; a set in the same cycle as a clear wins
    wire par_evt = !parity_err_n && !par_dis;
    wire chk_evt = !chan_check_n && !chk_dis;
    wire fst_evt = fail_safe_out && !fst_prev_ff && !fst_dis;
    wire sw_evt  = wr_sw && !sw_dis;

    // cpu ownership or master_ack stops the master count and zeroes it
    wire mst_run = master_owns_bus && !master_ack && !cpu_owns_bus;
    wire mst_to  = mst_run && (mst_cnt_ff == NMISL_CNT_W'(NMISL_MASTER_TO_CYC));
    wire cmd_run = !cmd_active_n;
    wire cmd_to  = cmd_run && (cmd_cnt_ff == NMISL_CNT_W'(NMISL_CMD_TO_CYC));
    wire bto_evt = (mst_to || cmd_to) && !bto_dis;

    wire nxt_par  = par_evt || (par_stat_ff && !par_clr);
    wire nxt_chk  = chk_evt || (chk_stat_ff && !chk_clr);
    wire nxt_fst  = fst_evt || (fst_stat_ff && !fst_clr);
    wire nxt_bto  = bto_evt || (bto_stat_ff && !bto_clr);
    wire nxt_sw   = sw_evt || (sw_stat_ff && !sw_clr);
    // released only by a write that leaves the timeout disable bit at zero
    wire to_rel   = wr_ext && !io_wdata[NMISL_EXT_BTO_DIS];
    wire nxt_to_rst = bto_evt || (to_rst_ff && !to_rel);

    wire [3:0] nxt_main_ctl = wr_main ? io_wdata[3:0] : main_ctl_ff;
    wire [3:0] nxt_ext_ctl  = wr_ext ? io_wdata[3:0] : ext_ctl_ff;
    wire [7:0] nxt_mask     = wr_mask ? io_wdata : mask_ff;

    // counters saturate one past the limit so the event fires once per hold
    wire [NMISL_CNT_W-1:0] nxt_mst_cnt =
        !mst_run ? '0 :
        (mst_cnt_ff > NMISL_CNT_W'(NMISL_MASTER_TO_CYC)) ? mst_cnt_ff :
        mst_cnt_ff + NMISL_CNT_W'(1);
    wire [NMISL_CNT_W-1:0] nxt_cmd_cnt =
        !cmd_run ? '0 :
        (cmd_cnt_ff > NMISL_CNT_W'(NMISL_CMD_TO_CYC)) ? cmd_cnt_ff :
        cmd_cnt_ff + NMISL_CNT_W'(1);

    wire [7:0] main_rd = {par_stat_ff, chk_stat_ff, 2'h0, main_ctl_ff};
    wire [7:0] ext_rd  = {fst_stat_ff, bto_stat_ff, sw_stat_ff, 1'h0, ext_ctl_ff};
    logic [7:0] nxt_rdata;

    // the trigger port is write-only, so it reads as zero like an unmapped port
    always_comb
    begin
        nxt_rdata = rdata_ff;
        if (io_rd && sel_main)
        begin
            nxt_rdata = main_rd;
        end
        else if (io_rd && sel_ext)
        begin
            nxt_rdata = ext_rd;
        end
        else if (io_rd && sel_mask)
        begin
            nxt_rdata = mask_ff;
        end
        else if (io_rd)
        begin
            nxt_rdata = 8'h00;
        end
    end

    wire any_pend = par_stat_ff || chk_stat_ff || fst_stat_ff || bto_stat_ff || sw_stat_ff;

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            main_ctl_ff <= NMISL_MAIN_CTL_RST;
        end
        else
        begin
            main_ctl_ff <= nxt_main_ctl;
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ext_ctl_ff <= NMISL_EXT_CTL_RST;
        end
        else
        begin
            ext_ctl_ff <= nxt_ext_ctl;
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mask_ff <= NMISL_MASK_RST;
        end
        else
        begin
            mask_ff <= nxt_mask;
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            par_stat_ff <= NMISL_STAT_RST;
        end
        else
        begin
            par_stat_ff <= nxt_par;
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            chk_stat_ff <= NMISL_STAT_RST;
        end
        else
        begin
            chk_stat_ff <= nxt_chk;
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            fst_stat_ff <= NMISL_STAT_RST;
        end
        else
        begin
            fst_stat_ff <= nxt_fst;
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            bto_stat_ff <= NMISL_STAT_RST;
        end
        else
        begin
            bto_stat_ff <= nxt_bto;
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sw_stat_ff <= NMISL_STAT_RST;
        end
        else
        begin
            sw_stat_ff <= nxt_sw;
        end
    end

    // resets to the idle low level of the pin, so no false edge follows reset
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            fst_prev_ff <= NMISL_STAT_RST;
        end
        else
        begin
            fst_prev_ff <= fail_safe_out;
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            to_rst_ff <= NMISL_STAT_RST;
        end
        else
        begin
            to_rst_ff <= nxt_to_rst;
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mst_cnt_ff <= NMISL_CNT_RST;
        end
        else
        begin
            mst_cnt_ff <= nxt_mst_cnt;
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cmd_cnt_ff <= NMISL_CNT_RST;
        end
        else
        begin
            cmd_cnt_ff <= nxt_cmd_cnt;
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rdata_ff <= NMISL_RDATA_RST;
        end
        else
        begin
            rdata_ff <= nxt_rdata;
        end
    end

    // a pending source stays a level, so a mask toggle yields a fresh edge
    assign nmi       = any_pend && !mask_ff[NMISL_MASK_ALL];
    assign bus_reset = to_rst_ff || ext_ctl_ff[NMISL_EXT_BUS_RST];
    assign io_rdata  = rdata_ff;

endmodule : nmisl_top

// [dv/nmisl_host.sv]
`timescale 1ns/1ps

module nmisl_host (
    input  wire logic clock,
    input  wire logic nmi,
    output int        edges
);
    logic prev_ff  = 1'b0;
    int   count_ff = 0;
    // the cpu sees edges only: a level that stays high raises nothing new
    always @(posedge clock)
    begin
        if (nmi && !prev_ff)
        begin
            count_ff <= count_ff + 1;
        end
        prev_ff <= nmi;
    end
    assign edges = count_ff;
endmodule : nmisl_host

// [dv/nmisl_chk.sv]
`timescale 1ns/1ps

module nmisl_chk (
    input wire logic        clock,
    input wire logic        rst_n,
    input wire logic [15:0] io_addr,
    input wire logic        io_wr,
    input wire logic [7:0]  io_wdata,
    input wire logic        parity_err_n,
    input wire logic        chan_check_n,
    input wire logic        fail_safe_out,
    input wire logic        cpu_owns_bus,
    input wire logic        cmd_active_n,
    input wire logic        nmi,
    input wire logic        bus_reset
);
    logic       mk_ff;
    logic [3:0] mc_ff;
    logic [3:0] ex_ff;
    wire w_main = io_wr && io_addr == 16'h0061;
    wire w_mask = io_wr && io_addr == 16'h0070;
    wire w_ext  = io_wr && io_addr == 16'h0461;
    wire w_sw   = io_wr && io_addr == 16'h0462;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n) {mk_ff, mc_ff, ex_ff} <= 9'h000;
        else
        begin
            if (w_mask) mk_ff <= io_wdata[7];
            if (w_main) mc_ff <= io_wdata[3:0];
            if (w_ext) ex_ff <= io_wdata[3:0];
        end
    end
    par_nmi_a: assert property (!parity_err_n && !mc_ff[2] && !mk_ff && !io_wr |=> nmi)
        else $error("parity error raised no nmi");
    chk_nmi_a: assert property (!chan_check_n && !mc_ff[3] && !mk_ff && !io_wr |=> nmi)
        else $error("channel check raised no nmi");
    fst_nmi_a: assert property ($rose(fail_safe_out) && !ex_ff[2] && !mk_ff && !io_wr |=> nmi)
        else $error("fail-safe edge raised no nmi");
    sw_nmi_a: assert property (w_sw && !ex_ff[1] && !mk_ff |=> nmi)
        else $error("trigger write raised no nmi");
    mask_gate_a: assert property (mk_ff |-> !nmi)
        else $error("nmi while masked");
    bto_nmi_a: assert property (bus_reset && !ex_ff[0] && !ex_ff[3] && !mk_ff |-> nmi)
        else $error("timeout reset without nmi");
    rst_hold_a: assert property (bus_reset && !ex_ff[0] && !w_ext |=> bus_reset)
        else $error("timeout reset dropped early");
    soft_rst_a: assert property (ex_ff[0] |-> bus_reset)
        else $error("bus reset bit not driven");
    cpu_no_bto_a: assert property (cpu_owns_bus && cmd_active_n && !io_wr && !bus_reset |=> !bus_reset)
        else $error("bus timeout while cpu owns bus");
    nmi_level_a: assert property (nmi && !io_wr |=> nmi)
        else $error("nmi dropped with source pending");
endmodule : nmisl_chk

bind nmisl_top nmisl_chk nmisl_chk_inst (
    .clock         (clock),
    .rst_n         (rst_n),
    .io_addr       (io_addr),
    .io_wr         (io_wr),
    .io_wdata      (io_wdata),
    .parity_err_n  (parity_err_n),
    .chan_check_n  (chan_check_n),
    .fail_safe_out (fail_safe_out),
    .cpu_owns_bus  (cpu_owns_bus),
    .cmd_active_n  (cmd_active_n),
    .nmi           (nmi),
    .bus_reset     (bus_reset)
);

// [dv/tb.sv]
`timescale 1ns/1ps

module tb;
    logic clock = 1'b0, rst_n = 1'b0, io_wr = 1'b0, io_rd = 1'b0, nmi, bus_reset;
    logic [15:0] io_addr = 16'h0000;
    logic [7:0]  io_wdata = 8'h00, io_rdata;
    logic parity_err_n = 1'b1, chan_check_n = 1'b1, fail_safe_out = 1'b0;
    logic master_owns_bus = 1'b0, master_ack = 1'b0, cpu_owns_bus = 1'b0, cmd_active_n = 1'b1;
    int fails = 0, n_tests = 0, edges;
    nmisl_top nmisl_top_inst (
        .clock           (clock),
        .rst_n           (rst_n),
        .io_addr         (io_addr),
        .io_wr           (io_wr),
        .io_rd           (io_rd),
        .io_wdata        (io_wdata),
        .io_rdata        (io_rdata),
        .parity_err_n    (parity_err_n),
        .chan_check_n    (chan_check_n),
        .fail_safe_out   (fail_safe_out),
        .master_owns_bus (master_owns_bus),
        .master_ack      (master_ack),
        .cpu_owns_bus    (cpu_owns_bus),
        .cmd_active_n    (cmd_active_n),
        .nmi             (nmi),
        .bus_reset       (bus_reset)
    );
    nmisl_host nmisl_host_inst (
        .clock (clock),
        .nmi   (nmi),
        .edges (edges)
    );
    initial forever #10 clock = ~clock;
    task chk(input string n, input logic [7:0] s, input logic [7:0] e);
        n_tests++;
        if (s !== e)
        begin
            fails++;
            $display("MISMATCH %s exp %h seen %h", n, e, s);
        end
    endtask : chk
    task wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clock);
        {io_addr, io_wdata, io_wr} <= {a, d, 1'b1};
        @(posedge clock);
        io_wr <= 1'b0;
        #1;
    endtask : wr
    task rd(input string n, input logic [15:0] a, input logic [7:0] e);
        @(posedge clock);
        {io_addr, io_rd} <= {a, 1'b1};
        @(posedge clock);
        io_rd <= 1'b0;
        #1 chk(n, io_rdata, e);
    endtask : rd
    task t_src;
        @(posedge clock);
        {parity_err_n, chan_check_n, fail_safe_out} <= 3'h1;
        @(posedge clock);
        {parity_err_n, chan_check_n, fail_safe_out} <= 3'h6;
        rd("main", 16'h0061, 8'hc0);
        rd("ext", 16'h0461, 8'h80);
        wr(16'h0061, 8'h0c);
        rd("main_clr", 16'h0061, 8'h0c);
        wr(16'h0461, 8'h04);
        wr(16'h0061, 8'h00);
        wr(16'h0461, 8'h00);
        chk("nmi_idle", {7'h00, nmi}, 8'h00);
    endtask : t_src
    task t_sw;
        int e;
        e = edges;
        wr(16'h0462, 8'h5a);
        chk("sw_nmi", {7'h00, nmi}, 8'h01);
        wr(16'h0070, 8'h80);
        chk("masked", {7'h00, nmi}, 8'h00);
        rd("mask", 16'h0070, 8'h80);
        wr(16'h0070, 8'h00);
        @(posedge clock);
        #1 chk("edges", 8'(edges - e), 8'h02);
        rd("sw_stat", 16'h0461, 8'h20);
        rd("sw_port", 16'h0462, 8'h00);
        rd("sw_stat2", 16'h0461, 8'h20);
        rd("unmapped", 16'h0060, 8'h00);
        wr(16'h0461, 8'h02);
        wr(16'h0461, 8'h00);
    endtask : t_sw
    task t_bto;
        int n;
        n = 0;
        @(posedge clock);
        master_owns_bus <= 1'b1;
        while (!bus_reset && n < 600)
        begin
            @(posedge clock);
            #1 n++;
        end
        if (bus_reset !== 1'b1)
        begin
            fails++;
            tally_and_finish;
        end
        chk("bto_time", 8'(n >= 399 && n <= 405), 8'h01);
        chk("bto_nmi", {7'h00, nmi}, 8'h01);
        @(posedge clock);
        master_owns_bus <= 1'b0;
        rd("bto_stat", 16'h0461, 8'h40);
        wr(16'h0461, 8'h08);
        chk("held", {7'h00, bus_reset}, 8'h01);
        wr(16'h0461, 8'h00);
        chk("freed", {7'h00, bus_reset}, 8'h00);
    endtask : t_bto
    task t_cmd;
        int n;
        n = 0;
        @(posedge clock);
        cmd_active_n <= 1'b0;
        while (!bus_reset && n < 2000)
        begin
            @(posedge clock);
            #1 n++;
        end
        if (bus_reset !== 1'b1)
        begin
            fails++;
            tally_and_finish;
        end
        chk("cmd_time", 8'(n >= 1599 && n <= 1605), 8'h01);
        chk("cmd_nmi", {7'h00, nmi}, 8'h01);
        @(posedge clock);
        cmd_active_n <= 1'b1;
        rd("cmd_stat", 16'h0461, 8'h40);
        wr(16'h0461, 8'h08);
        chk("cmd_held", {7'h00, bus_reset}, 8'h01);
        wr(16'h0461, 8'h00);
        chk("cmd_freed", {6'h00, nmi, bus_reset}, 8'h00);
    endtask : t_cmd
    task t_rst;
        wr(16'h0461, 8'h01);
        wr(16'h0462, 8'h00);
        chk("pre_rst", {6'h00, nmi, bus_reset}, 8'h03);
        @(posedge clock);
        rst_n <= 1'b0;
        @(posedge clock);
        #1 chk("rst_out", {6'h00, nmi, bus_reset}, 8'h00);
        chk("rst_rdata", io_rdata, 8'h00);
        @(posedge clock);
        rst_n <= 1'b1;
        rd("rst_ext", 16'h0461, 8'h00);
        rd("rst_mask", 16'h0070, 8'h00);
    endtask : t_rst
    task t_cpu;
        @(posedge clock);
        {master_owns_bus, cpu_owns_bus} <= 2'h3;
        repeat (500) @(posedge clock);
        {cpu_owns_bus, master_ack} <= 2'h1;
        repeat (500) @(posedge clock);
        {master_owns_bus, master_ack} <= 2'h0;
        #1 chk("no_bto", {6'h00, nmi, bus_reset}, 8'h00);
    endtask : t_cpu
    task t_soft;
        wr(16'h0461, 8'h01);
        chk("soft_rst", {6'h00, nmi, bus_reset}, 8'h01);
        wr(16'h0461, 8'h00);
        chk("soft_off", {7'h00, bus_reset}, 8'h00);
    endtask : t_soft
    task tally_and_finish;
        $display("tests %0d fails %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : tally_and_finish
    initial
    begin
        repeat (6) @(posedge clock);
        rst_n <= 1'b1;
        t_src;
        t_sw;
        t_bto;
        t_cmd;
        t_cpu;
        t_soft;
        t_rst;
        tally_and_finish;
    end
endmodule : tb
